// ---- wdog_pkg.sv ----
/*
 * wdog_pkg: register map, field positions, reset values and encodings
 * shared by the watchdog control block and its time-out counter.
 * assumes byte addressing on a 32-bit avalon-mm bus, one register a word.
 */
package wdog_pkg;

   // ==========================================================
   // bus shape
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // ==========================================================
   // register byte offsets
   localparam logic [ADDR_W-1:0] CTRL_OFS    = 8'h0c;
   localparam logic [ADDR_W-1:0] CLKCFG_OFS  = 8'h10;
   localparam logic [ADDR_W-1:0] SERVICE_OFS = 8'h14;
   localparam logic [ADDR_W-1:0] STATUS_OFS  = 8'h18;

   // ==========================================================
   // watchdog_control fields
   localparam int WIN_BIT   = 7;
   localparam int HALT_BIT  = 6;
   localparam int GUARD_BIT = 5;
   localparam int RATE_LSB  = 0;
   localparam int RATE_W    = 3;
   localparam logic [RATE_W-1:0] RATE_OFF = 3'h0;

   // ==========================================================
   // clock configuration fields and reset value
   localparam int SEL_LO_BIT = 0;
   localparam int SEL_HI_BIT = 1;
   localparam int PSE_BIT    = 2;
   localparam logic [2:0] CLKCFG_RST = 3'h0;

   // ==========================================================
   // service sequence and status fields
   localparam logic [7:0] SERVICE_ARM  = 8'h55;
   localparam logic [7:0] SERVICE_FIRE = 8'haa;
   localparam int ST_EN_BIT   = 0;
   localparam int ST_WIN_BIT  = 1;
   localparam int ST_ONCE_BIT = 2;
   localparam int ST_LOAD_BIT = 3;

   // ==========================================================
   // counter sizing
   localparam int CNT_W = 25;
   localparam logic [4:0] MAX_EXP = 5'h18;

   typedef enum logic [0:0] {
      LOAD_WAIT = 1'b0,
      LOAD_DONE = 1'b1
   } load_state_t;

endpackage

// ---- wdog_counter.sv ----
/*
 * wdog_counter: time-out counter of the watchdog, advanced by a
 * one-cycle tick of the selected watchdog clock.
 * assumes tick, run and restart come from logic on clk.
 */
`timescale 1ns/10ps
module wdog_counter
   import wdog_pkg::*;
(
   // clock and reset
   input  wire logic               clk,
   input  wire logic               rst,
   // control
   input  wire logic               tick,
   input  wire logic               run,
   input  wire logic               restart,
   input  wire logic [RATE_W-1:0]  rate_sel,
   input  wire logic               fast_clk,
   input  wire logic               force_max,
   // state
   output logic                    expired,
   output logic                    in_window
);

   logic [4:0]       exp_sel;
   logic [CNT_W-1:0] term;
   logic [CNT_W-1:0] count;

   // ==========================================================
   // period lookup: slow sources use the long table
   function automatic logic [4:0] period_exp(logic [2:0] r, logic fast);
      logic [4:0] e;
      e = 5'h00;
      unique case (r)
         3'h1: e = fast ? 5'h07 : 5'h0e;
         3'h2: e = fast ? 5'h09 : 5'h10;
         3'h3: e = fast ? 5'h0b : 5'h12;
         3'h4: e = fast ? 5'h0d : 5'h14;
         3'h5: e = fast ? 5'h0f : 5'h16;
         3'h6: e = fast ? 5'h10 : 5'h17;
         3'h7: e = fast ? 5'h11 : 5'h18;
         3'h0: e = 5'h00;
      endcase
      return e;
   endfunction

   assign exp_sel   = force_max ? MAX_EXP : period_exp(rate_sel, fast_clk);
   assign term      = CNT_W'(1) << exp_sel;
   // last quarter of the period is the service window
   assign in_window = count >= (term - (term >> 2));
   assign expired   = tick && run && (rate_sel != RATE_OFF) && (count == term - CNT_W'(1));

   // ==========================================================
   // counting
   always_ff @(posedge clk) begin
      if (rst || restart || (rate_sel == RATE_OFF)) begin
         count <= '0;
      end else if (tick && run) begin
         count <= expired ? '0 : count + CNT_W'(1);
      end
   end

endmodule // wdog_counter

// ---- wdog_ctrl.sv ----
/*
 * wdog_ctrl: watchdog control block with clock selection, stop-mode
 * gating, nonvolatile load, write protection and restart sources.
 * assumes an avalon-mm master on clk, clock ticks arriving on pins,
 * and an nvm loader on clk that strobes once after system reset.
 */
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/10ps
// Operation
// - counter clock is autonomous, internal rc or crystal, by two select bits
// - pseudo-stop keeps it running with lo set, hi clear, enable set; else halts
// - with clock-select-high set the counter runs in every stop mode
// - control register at 0x0c loads from nvm after reset release
// - debug-halt bit free in special mode; normal mode may only set it
// - special mode: window and rate bits writable any time unless guarded
// - normal mode: window and rate bits take one unguarded write only
// - writing rate 000 leaves the field but uses the single write
// - writing window 0 leaves the bit but uses the single write
// - non-zero rate loaded from nvm starts a time-out period
// - clock-select change or osc-good loss with lo-only selection restarts
// - normal mode restarts on counted rate or window write, or halt set
// - special mode: any control write restarts the period
// - non-zero rate enables counter; expiry resets unless serviced
// - write guard is write-only; guarded writes skip window, rate, once count
// - rate codes 1-7 give periods 2^14 to 2^24 (2^7 to 2^17 with clock-select-high set); zero disables
// - window mode outside special-mode debug without halt: service only in the last quarter, else reset
module wdog_ctrl
   import wdog_pkg::*;
(
   // clock and reset
   input  wire logic                          clk,
   input  wire logic                          rst,
   // avalon-mm slave
   input  wire logic [wdog_pkg::ADDR_W-1:0]   address,
   input  wire logic                          read,
   input  wire logic                          write,
   input  wire logic [wdog_pkg::DATA_W-1:0]   writedata,
   output logic      [wdog_pkg::DATA_W-1:0]   readdata,
   output logic                               waitrequest,
   // watchdog clock ticks, from pins
   input  wire logic                          autonomous_clock,
   input  wire logic                          internal_rc_clock,
   input  wire logic                          crystal_osc_clock,
   input  wire logic                          osc_good_flag,
   // chip modes, from logic on clk
   input  wire logic                          special_mode,
   input  wire logic                          stop_mode,
   input  wire logic                          pseudo_stop_select,
   input  wire logic                          background_debug,
   // nonvolatile load, from logic on clk
   input  wire logic                          nvm_valid,
   input  wire logic [7:0]                    nvm_data,
   // reset request
   output logic                               wdog_reset
);

   // ==========================================================
   // declarations
   logic [3:0]        sync1;
   logic [3:0]        sync2;
   logic [3:0]        sync3;
   logic              aclk_rise;
   logic              irc_rise;
   logic              osc_rise;
   logic              osc_lost;
   logic              aclk_half;
   logic              tick;
   logic              run;
   logic              window_mode;
   logic              halt_in_debug;
   logic [RATE_W-1:0] timeout_rate_sel;
   logic              written_once;
   logic              wdog_clk_sel_lo;
   logic              wdog_clk_sel_hi;
   logic              wdog_pseudo_stop_enable;
   logic              service_armed;
   load_state_t       load_state;
   logic              load_now;
   logic              wr_en;
   logic              ctrl_wr;
   logic              clk_wr;
   logic              svc_wr;
   logic              counted_wr;
   logic              halt_set;
   logic              restart_ctrl;
   logic              restart_clk;
   logic              restart_nvm;
   logic              service_ok;
   logic              service_bad;
   logic              restart;
   logic              enabled;
   logic              force_max;
   logic              expired;
   logic              in_window;
   logic [DATA_W-1:0] next_readdata;

   // ==========================================================
   // address decode, shared by read and write paths
   function automatic logic hit(logic [ADDR_W-1:0] a, logic [ADDR_W-1:0] ofs);
      return a == ofs;
   endfunction

   // ==========================================================
   // pin synchronisers: second stage feeds the edge detect
   generate
      for (genvar i = 0; i < 4; i++) begin : g_sync
         always_ff @(posedge clk) begin
            if (rst) begin
               sync1[i] <= 1'b0;
               sync2[i] <= 1'b0;
               sync3[i] <= 1'b0;
            end else begin
               sync1[i] <= i == 0 ? autonomous_clock :
                           i == 1 ? internal_rc_clock :
                           i == 2 ? crystal_osc_clock : osc_good_flag;
               sync2[i] <= sync1[i];
               sync3[i] <= sync2[i];
            end
         end
      end
   endgenerate

   assign aclk_rise = sync2[0] & ~sync3[0];
   assign irc_rise  = sync2[1] & ~sync3[1];
   assign osc_rise  = sync2[2] & ~sync3[2];
   assign osc_lost  = ~sync2[3] & sync3[3];

   // autonomous clock counts at half rate
   always_ff @(posedge clk) begin
      if (rst) begin
         aclk_half <= 1'b0;
      end else if (aclk_rise) begin
         aclk_half <= ~aclk_half;
      end
   end

   // ==========================================================
   // clock source and run gating
   always_comb begin
      if (wdog_clk_sel_hi) begin
         tick = aclk_rise & aclk_half;
      end else if (wdog_clk_sel_lo) begin
         tick = osc_rise;
      end else begin
         tick = irc_rise;
      end
   end

   // stop gating; halt in debug only when asked
   assign run = (~stop_mode
                 | wdog_clk_sel_hi
                 | (pseudo_stop_select & wdog_clk_sel_lo & wdog_pseudo_stop_enable))
                & ~(halt_in_debug & background_debug);

   assign enabled   = timeout_rate_sel != RATE_OFF;
   // debug in special mode without halt runs the longest plain period
   assign force_max = enabled & background_debug & ~halt_in_debug & special_mode;

   // ==========================================================
   // avalon handshake: one wait cycle, then the access completes
   always_ff @(posedge clk) begin
      if (rst) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= ~((read | write) & waitrequest);
      end
   end

   assign wr_en   = write & ~waitrequest;
   assign ctrl_wr = wr_en & hit(address, CTRL_OFS);
   assign clk_wr  = wr_en & hit(address, CLKCFG_OFS);
   assign svc_wr  = wr_en & hit(address, SERVICE_OFS);

   // ==========================================================
   // read mux; write guard never reads back
   always_comb begin
      next_readdata = '0;
      if (hit(address, CTRL_OFS)) begin
         next_readdata[WIN_BIT]  = window_mode;
         next_readdata[HALT_BIT] = halt_in_debug;
         next_readdata[RATE_LSB +: RATE_W] = timeout_rate_sel;
      end else if (hit(address, CLKCFG_OFS)) begin
         next_readdata[SEL_LO_BIT] = wdog_clk_sel_lo;
         next_readdata[SEL_HI_BIT] = wdog_clk_sel_hi;
         next_readdata[PSE_BIT]    = wdog_pseudo_stop_enable;
      end else if (hit(address, STATUS_OFS)) begin
         next_readdata[ST_EN_BIT]   = enabled;
         next_readdata[ST_WIN_BIT]  = in_window;
         next_readdata[ST_ONCE_BIT] = written_once;
         next_readdata[ST_LOAD_BIT] = load_state == LOAD_DONE;
      end
   end

   // data is captured as waitrequest drops and holds to the next read
   always_ff @(posedge clk) begin
      if (rst) begin
         readdata <= '0;
      end else if (read & waitrequest) begin
         readdata <= next_readdata;
      end
   end

   // ==========================================================
   // nonvolatile load after reset release
   always_ff @(posedge clk) begin
      if (rst) begin
         load_state <= LOAD_WAIT;
      end else begin
         unique case (load_state)
            LOAD_WAIT: if (nvm_valid) begin
               load_state <= LOAD_DONE;
            end
            LOAD_DONE: load_state <= LOAD_DONE;
         endcase
      end
   end

   assign load_now = (load_state == LOAD_WAIT) & nvm_valid;

   // ==========================================================
   // write classification
   // a counted write is an unguarded first write in normal mode
   assign counted_wr = ctrl_wr & ~special_mode & ~writedata[GUARD_BIT] & ~written_once;
   assign halt_set   = ctrl_wr & writedata[HALT_BIT] & ~halt_in_debug;

   assign restart_ctrl = (ctrl_wr & special_mode)
                         | counted_wr
                         | (halt_set & ~special_mode);

   assign restart_clk = (clk_wr & ((writedata[SEL_LO_BIT] != wdog_clk_sel_lo)
                                   | (writedata[SEL_HI_BIT] != wdog_clk_sel_hi)))
                        | (osc_lost & ~wdog_clk_sel_hi & wdog_clk_sel_lo);

   assign restart_nvm = load_now & (nvm_data[RATE_LSB +: RATE_W] != RATE_OFF);

   assign restart = restart_ctrl | restart_clk | restart_nvm | service_ok;

   // ==========================================================
   // window and rate fields
   always_ff @(posedge clk) begin
      if (rst) begin
         window_mode      <= 1'b0;
         timeout_rate_sel <= RATE_OFF;
      end else if (load_now) begin
         window_mode      <= nvm_data[WIN_BIT];
         timeout_rate_sel <= nvm_data[RATE_LSB +: RATE_W];
      end else if (ctrl_wr & special_mode & ~writedata[GUARD_BIT]) begin
         window_mode      <= writedata[WIN_BIT];
         timeout_rate_sel <= writedata[RATE_LSB +: RATE_W];
      end else if (counted_wr) begin
         if (writedata[WIN_BIT]) begin
            window_mode <= 1'b1;
         end
         if (writedata[RATE_LSB +: RATE_W] != RATE_OFF) begin
            timeout_rate_sel <= writedata[RATE_LSB +: RATE_W];
         end
      end
   end

   // guarded writes never use up the single write
   always_ff @(posedge clk) begin
      if (rst) begin
         written_once <= 1'b0;
      end else if (counted_wr) begin
         written_once <= 1'b1;
      end
   end

   // ==========================================================
   // debug-halt bit
   always_ff @(posedge clk) begin
      if (rst) begin
         halt_in_debug <= 1'b0;
      end else if (load_now) begin
         halt_in_debug <= nvm_data[HALT_BIT];
      end else if (ctrl_wr & special_mode) begin
         halt_in_debug <= writedata[HALT_BIT];
      end else if (halt_set) begin
         halt_in_debug <= 1'b1;
      end
   end

   // ==========================================================
   // clock configuration
   always_ff @(posedge clk) begin
      if (rst) begin
         wdog_clk_sel_lo         <= CLKCFG_RST[SEL_LO_BIT];
         wdog_clk_sel_hi         <= CLKCFG_RST[SEL_HI_BIT];
         wdog_pseudo_stop_enable <= CLKCFG_RST[PSE_BIT];
      end else if (clk_wr) begin
         wdog_clk_sel_lo         <= writedata[SEL_LO_BIT];
         wdog_clk_sel_hi         <= writedata[SEL_HI_BIT];
         wdog_pseudo_stop_enable <= writedata[PSE_BIT];
      end
   end

   // ==========================================================
   // service sequence; ignored while the watchdog is off
   always_comb begin
      service_ok  = 1'b0;
      service_bad = 1'b0;
      if (svc_wr & enabled) begin
         if (window_mode & ~force_max & ~in_window) begin
            service_bad = 1'b1;
         end else if (writedata[7:0] == SERVICE_FIRE && service_armed) begin
            service_ok = 1'b1;
         end else if (writedata[7:0] != SERVICE_ARM) begin
            service_bad = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst || restart_ctrl || restart_clk || restart_nvm) begin
         service_armed <= 1'b0;
      end else if (svc_wr & enabled & ~service_bad) begin
         service_armed <= writedata[7:0] == SERVICE_ARM;
      end
   end

   // ==========================================================
   // time-out counter
   wdog_counter u_counter (
      .clk       (clk),
      .rst       (rst),
      .tick      (tick),
      .run       (run),
      .restart   (restart),
      .rate_sel  (timeout_rate_sel),
      .fast_clk  (wdog_clk_sel_hi),
      .force_max (force_max),
      .expired   (expired),
      .in_window (in_window)
   );

   // held until the system reset that it requests
   always_ff @(posedge clk) begin
      if (rst) begin
         wdog_reset <= 1'b0;
      end else if (expired | service_bad) begin
         wdog_reset <= 1'b1;
      end
   end

endmodule // wdog_ctrl

// ---- wdog_ctrl_sva.sv ----
/*
 * wdog_ctrl_sva: bus timing, read-back and reset-request checks on the
 * ports of the watchdog control block.
 * assumes binding to wdog_ctrl, one clock clk and synchronous reset rst.
 */
`timescale 1ns/10ps
module wdog_ctrl_sva
   import wdog_pkg::*;
(
   // clock and reset
   input wire logic                          clk,
   input wire logic                          rst,
   // avalon-mm slave
   input wire logic [wdog_pkg::ADDR_W-1:0]   address,
   input wire logic                          read,
   input wire logic                          write,
   input wire logic [wdog_pkg::DATA_W-1:0]   readdata,
   input wire logic                          waitrequest,
   // reset request
   input wire logic                          wdog_reset
);
   import wdog_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // ========
   // bus handshake
   idle_wait_a: assert property (!read && !write |-> waitrequest)
      else $error("waitrequest low with no request");
   one_wait_a: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("request not answered after one wait cycle");
   ans_short_a: assert property (!waitrequest |=> waitrequest)
      else $error("answer held longer than one cycle");
   // readdata may only move at the edge that takes a read
   rd_hold_a: assert property (!(read && waitrequest) |=> $stable(readdata))
      else $error("readdata changed without a read");

   // ========
   // read-back contents
   rd_upper_a: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   rd_guard_a: assert property (read && !waitrequest && address == CTRL_OFS
      |-> readdata[5:3] == 3'h0)
      else $error("write guard or reserved bits read non-zero");
   rd_unmap_a: assert property (read && !waitrequest && address != CTRL_OFS
      && address != CLKCFG_OFS && address != STATUS_OFS |-> readdata == 32'h0)
      else $error("unmapped or write-only read non-zero");

   // ========
   // reset request
   rst_sticky_a: assert property (wdog_reset |=> wdog_reset)
      else $error("reset request dropped before rst");
   rst_clear_a: assert property ($past(rst) |-> !wdog_reset && waitrequest && readdata == 32'h0)
      else $error("outputs not cleared by rst");

   cover property (write && !waitrequest && address == CTRL_OFS);
   cover property (read && !waitrequest && address == CTRL_OFS);
   cover property ($rose(wdog_reset));
endmodule // wdog_ctrl_sva

bind wdog_ctrl wdog_ctrl_sva chk_u (
   .clk         (clk),
   .rst         (rst),
   .address     (address),
   .read        (read),
   .write       (write),
   .readdata    (readdata),
   .waitrequest (waitrequest),
   .wdog_reset  (wdog_reset)
);

// ---- wdog_ctrl_tb_top.sv ----
/*
 * wdog_ctrl_tb_top: self-checking bench for the watchdog control block,
 * with a bit model of the control register and expiry timing.
 * assumes the checker is bound in by its own file.
 */
`timescale 1ns/10ps
module wdog_ctrl_tb_top;
   import wdog_pkg::*;
   // ========
   // signals
   logic                clk         = 1'b0;
   logic                rst         = 1'b1;
   logic [ADDR_W-1:0]   address     = '0;
   logic                read        = 1'b0;
   logic                write       = 1'b0;
   logic [DATA_W-1:0]   writedata   = '0;
   logic [DATA_W-1:0]   readdata;
   logic                waitrequest;
   logic                aclk        = 1'b0;
   logic                aph         = 1'b0;
   logic                aclk_run    = 1'b0;
   logic                osc_good    = 1'b1;
   logic                special     = 1'b0;
   logic                stop        = 1'b0;
   logic                debug       = 1'b0;
   logic                pstop       = 1'b0;
   logic                nvm_valid   = 1'b0;
   logic [7:0]          nvm_data    = 8'h0;
   logic                wdog_reset;
   logic [DATA_W-1:0]   q;
   logic [7:0]          d;
   int                  n_fail      = 0;
   int                  comparisons = 0;
   int                  m_win, m_halt, m_rate, m_once, n, k;

   always #2.5 clk = ~clk;
   // autonomous clock: 2 cycles high, 2 low, so one tick every 8 cycles
   always @(posedge clk) begin
      if (aclk_run) begin
         aph <= ~aph;
         if (aph) aclk <= ~aclk;
      end
   end

   wdog_ctrl dut_u (
      .clk                (clk),
      .rst                (rst),
      .address            (address),
      .read               (read),
      .write              (write),
      .writedata          (writedata),
      .readdata           (readdata),
      .waitrequest        (waitrequest),
      .autonomous_clock   (aclk),
      .internal_rc_clock  (aclk),
      .crystal_osc_clock  (aclk),
      .osc_good_flag      (osc_good),
      .special_mode       (special),
      .stop_mode          (stop),
      .pseudo_stop_select (pstop),
      .background_debug   (debug),
      .nvm_valid          (nvm_valid),
      .nvm_data           (nvm_data),
      .wdog_reset         (wdog_reset)
   );

   // ========
   // tasks
   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [DATA_W-1:0] exp,
                      input logic [DATA_W-1:0] got);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   // held until waitrequest is sampled low; the bound catches a hung slave
   task automatic bus(input logic rd, input logic [ADDR_W-1:0] a, input logic [7:0] wd);
      int i;
      @(posedge clk);
      read <= rd;
      write <= !rd;
      address <= a;
      writedata <= {24'h0, wd};
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (waitrequest !== 1'b0 && i < 20);
      if (waitrequest !== 1'b0) begin
         chk("waitrequest", 32'h0, {31'h0, waitrequest});
         wrap_up();
      end
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic do_reset();
      @(posedge clk);
      rst <= 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      m_win = 0;
      m_halt = 0;
      m_rate = 0;
      m_once = 0;
   endtask

   // bounded wait for the reset request; a hang ends the run
   task automatic wait_rst(input int lim);
      n = 0;
      while (wdog_reset !== 1'b1 && n < lim) begin
         @(posedge clk);
         n++;
      end
      if (wdog_reset !== 1'b1) begin
         chk("wdog_reset", 32'h1, {31'h0, wdog_reset});
         wrap_up();
      end
   endtask

   // write, update the model, read back and compare
   task automatic wr_ctrl(input logic [7:0] wd);
      bus(1'b0, CTRL_OFS, wd);
      if (special) begin
         m_halt = wd[HALT_BIT];
         if (!wd[GUARD_BIT]) begin
            m_win = wd[WIN_BIT];
            m_rate = wd[2:0];
         end
      end else begin
         if (wd[HALT_BIT]) m_halt = 1;
         if (!wd[GUARD_BIT] && m_once == 0) begin
            m_once = 1;
            if (wd[WIN_BIT]) m_win = 1;
            if (wd[2:0] != 3'h0) m_rate = wd[2:0];
         end
      end
      bus(1'b1, CTRL_OFS, 8'h0);
      chk("watchdog_control", {24'h0, m_win[0], m_halt[0], 3'h0, m_rate[2:0]}, q);
   endtask

   // ========
   // sequence
   initial begin
      void'($urandom(32'h14bd9692));
      do_reset();
      bus(1'b1, CTRL_OFS, 8'h0);
      chk("watchdog_control", 32'h0, q);
      bus(1'b0, 8'h20, 8'hff);
      bus(1'b1, 8'h20, 8'h0);
      chk("unmapped", 32'h0, q);
      // only the first load pulse after reset counts
      for (k = 0; k < 2; k++) begin
         @(posedge clk);
         nvm_data <= k ? 8'h03 : 8'h81;
         nvm_valid <= 1'b1;
         @(posedge clk);
         nvm_valid <= 1'b0;
      end
      bus(1'b1, CTRL_OFS, 8'h0);
      chk("nvm load", 32'h81, q);
      bus(1'b1, STATUS_OFS, 8'h0);
      chk("status", 32'h9, q & 32'h9);
      m_win = 1;
      m_rate = 1;
      debug <= 1'($urandom);
      wr_ctrl(8'h40);
      wr_ctrl(8'h02);
      do_reset();
      wr_ctrl(8'h23);
      wr_ctrl(8'h85);
      wr_ctrl(8'h03);
      do_reset();
      debug <= 1'b0;
      special <= 1'b1;
      for (k = 0; k < 12; k++) begin
         osc_good <= 1'($urandom);
         d = 8'($urandom);
         if (d[2:0] == 3'h0) d[0] = 1'b1;
         wr_ctrl(d);
      end
      // restart mid-period by control write, halt set, clock change and service, then time the expiry in stop mode
      for (k = 0; k < 4; k++) begin
         do_reset();
         special <= (k != 1);
         stop <= 1'b1;
         aclk_run <= 1'b1;
         bus(1'b0, CLKCFG_OFS, 8'h02);
         bus(1'b1, CLKCFG_OFS, 8'h0);
         chk("clock config", 32'h2, q);
         wr_ctrl(8'h01);
         repeat (600) @(posedge clk);
         chk("early expiry", 32'h0, {31'h0, wdog_reset});
         if (k == 2) bus(1'b0, CLKCFG_OFS, 8'h03);
         else if (k == 3) begin
            bus(1'b0, SERVICE_OFS, SERVICE_ARM);
            bus(1'b0, SERVICE_OFS, SERVICE_FIRE);
         end else wr_ctrl(k ? 8'h40 : 8'h01);
         wait_rst(2000);
         chk("expiry in window", 32'h1, {31'h0, n >= 990 && n <= 1040});
      end
      // window mode: a service early in the period requests reset
      do_reset();
      bus(1'b0, CLKCFG_OFS, 8'h02);
      wr_ctrl(8'h81);
      bus(1'b0, SERVICE_OFS, SERVICE_ARM);
      @(posedge clk);
      chk("early service", 32'h1, {31'h0, wdog_reset});
      // pseudo-stop on the crystal source keeps the slow period running
      do_reset();
      pstop <= 1'b1;
      osc_good <= 1'b1;
      bus(1'b0, CLKCFG_OFS, 8'h05);
      wr_ctrl(8'h01);
      wait_rst(70000);
      chk("pseudo-stop expiry", 32'h1, {31'h0, n >= 65500 && n <= 65600});
      aclk_run <= 1'b0;
      do_reset();
      wrap_up();
   end
endmodule // wdog_ctrl_tb_top
